// >>> hdl/msu_regs.svh
// Constants for the multiply-subtract unit.
`ifndef MSU_REGS_SVH
`define MSU_REGS_SVH
`define MSU_WORD_W      32
`define MSU_GPR_W       64
`define MSU_PROD_W      64
`define MSU_HALF_W      16
`define MSU_DEST_W      5
`define MSU_LAT_SHORT   2
`define MSU_LAT_LONG    3
`define MSU_CNT_W       2
`define MSU_CNT_ZERO    2'h0
`define MSU_ZERO64      64'h0000_0000_0000_0000
`define MSU_ZERO5       5'h0
`endif

// >>> hdl/msu_pkg.sv
// Types shared by the multiply-subtract unit.
package msu_pkg;
  typedef enum logic [1:0] {
    MSU_OP_SUBS = 2'h0,
    MSU_OP_SUBU = 2'h1,
    MSU_OP_MULR = 2'h2,
    MSU_OP_NONE = 2'h3
  } msu_op_t;

  typedef enum logic [2:0] {
    MSU_ST_IDLE = 3'h1,
    MSU_ST_BUSY = 3'h2,
    MSU_ST_DONE = 3'h4
  } msu_state_t;
endpackage : msu_pkg

// >>> hdl/msu_mult_array.sv
// Combinational 32 x 32 multiplier with signed or unsigned operand extension.
`timescale 1ns/1ns
`include "msu_regs.svh"
module msu_mult_array (
  input  wire logic [`MSU_WORD_W-1:0] opA,
  input  wire logic [`MSU_WORD_W-1:0] opB,
  input  wire logic                   isSigned,
  output logic      [`MSU_PROD_W-1:0] product,
  output logic                        shortB
);
  logic [`MSU_PROD_W-1:0] extA;
  logic [`MSU_PROD_W-1:0] extB;
  logic [`MSU_PROD_W-1:0] full;

  // Operands are widened by sign or zero, then the low 64 bits of the product are kept.
  always_comb begin
    extA    = isSigned ? {{`MSU_WORD_W{opA[`MSU_WORD_W-1]}}, opA}
                       : {{`MSU_WORD_W{1'b0}}, opA};
    extB    = isSigned ? {{`MSU_WORD_W{opB[`MSU_WORD_W-1]}}, opB}
                       : {{`MSU_WORD_W{1'b0}}, opB};
    full    = extA * extB;
    product = full;
    // The second operand is short when its top half is only sign or zero fill.
    shortB  = isSigned ? (opB[`MSU_WORD_W-1:`MSU_HALF_W-1] == '0 ||
                          opB[`MSU_WORD_W-1:`MSU_HALF_W-1] == '1)
                       : (opB[`MSU_WORD_W-1:`MSU_HALF_W] == '0);
  end
endmodule : msu_mult_array

// >>> hdl/msu_unit.sv
// Multiply-subtract datapath with accumulator pair and register-writing multiply.
// Summary of operation
// - Signed subtract form multiplies low words of both sources as two's complement.
// - Product is subtracted from accum_top low word over accum_bottom low word.
// - Result upper half goes to accum_top, lower to accum_bottom, both sign-extended.
// - Unsigned subtract form zero-extends both words; write-back same as signed.
// - No arithmetic exception is ever raised by any operation.
// - Subtract forms update only the accumulators, never a general register.
// - Register multiply writes sign-extended low product word to destination.
// - Latency assumes the shorter operand arrives on src_b.
`timescale 1ns/1ns
`include "msu_regs.svh"
module msu_unit #(
  parameter int LAT_SHORT = `MSU_LAT_SHORT,
  parameter int LAT_LONG  = `MSU_LAT_LONG
) (
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic                   issueValid,
  input  wire logic [1:0]             issueOp,
  input  wire logic [`MSU_GPR_W-1:0]  srcA,
  input  wire logic [`MSU_GPR_W-1:0]  srcB,
  input  wire logic [`MSU_DEST_W-1:0] destSel,
  output logic                        busy,
  output logic                        stallAccum,
  output logic                        stallDest,
  output logic [`MSU_DEST_W-1:0]      pendDest,
  output logic [`MSU_GPR_W-1:0]       accumTop,
  output logic [`MSU_GPR_W-1:0]       accumBottom,
  output logic                        gprWrEn,
  output logic [`MSU_DEST_W-1:0]      gprWrSel,
  output logic [`MSU_GPR_W-1:0]       gprWrData,
  output logic                        arithExc
);
  typedef struct packed {
    msu_pkg::msu_state_t         state;
    msu_pkg::msu_op_t            op;
    logic [`MSU_CNT_W-1:0]       cnt;
    logic [`MSU_WORD_W-1:0]      opA;
    logic [`MSU_WORD_W-1:0]      opB;
    logic [`MSU_DEST_W-1:0]      dest;
    logic [`MSU_GPR_W-1:0]       top;
    logic [`MSU_GPR_W-1:0]       bottom;
    logic                        wrEn;
    logic [`MSU_DEST_W-1:0]      wrSel;
    logic [`MSU_GPR_W-1:0]       wrData;
    logic                        stA;
    logic                        stD;
    logic                        bsy;
    logic                        exc;
  } msu_st_t;

  msu_st_t                state_ff;
  msu_st_t                nxt_state;
  logic [`MSU_PROD_W-1:0] product;
  logic                   shortB;
  logic [`MSU_PROD_W-1:0] accum;
  logic [`MSU_PROD_W-1:0] diff;

  // Widen a 32-bit word by its sign to full register width.
  function automatic logic [`MSU_GPR_W-1:0] sext(input logic [`MSU_WORD_W-1:0] w);
    sext = {{(`MSU_GPR_W-`MSU_WORD_W){w[`MSU_WORD_W-1]}}, w};
  endfunction : sext

  msu_mult_array u_mult (
    .opA      (state_ff.opA),
    .opB      (state_ff.opB),
    .isSigned (state_ff.op != msu_pkg::MSU_OP_SUBU),
    .product  (product),
    .shortB   (shortB)
  );

  // Next state: capture, count latency, then write back results.
  always_comb begin
    nxt_state      = state_ff;
    nxt_state.wrEn = 1'b0;
    accum = {state_ff.top[`MSU_WORD_W-1:0], state_ff.bottom[`MSU_WORD_W-1:0]};
    diff  = accum - product;  // wraps silently, no overflow detect
    case (state_ff.state)
      msu_pkg::MSU_ST_IDLE: begin
        if (issueValid && issueOp != msu_pkg::MSU_OP_NONE) begin
          nxt_state.state = msu_pkg::MSU_ST_BUSY;
          nxt_state.op    = msu_pkg::msu_op_t'(issueOp);
          nxt_state.opA   = srcA[`MSU_WORD_W-1:0];  // upper bits assumed equal
          nxt_state.opB   = srcB[`MSU_WORD_W-1:0];
          nxt_state.dest  = destSel;
          nxt_state.cnt   = `MSU_CNT_ZERO;
          nxt_state.stA   = (issueOp != 2'(msu_pkg::MSU_OP_MULR));
          nxt_state.stD   = (issueOp == 2'(msu_pkg::MSU_OP_MULR));
        end
      end
      msu_pkg::MSU_ST_BUSY: begin
        nxt_state.cnt = state_ff.cnt + 1'b1;
        // A short src_b finishes one cycle sooner.
        if (32'(state_ff.cnt) + 1 >= (shortB ? LAT_SHORT : LAT_LONG) - 1) begin
          nxt_state.state = msu_pkg::MSU_ST_DONE;
        end
      end
      msu_pkg::MSU_ST_DONE: begin
        if (state_ff.op == msu_pkg::MSU_OP_MULR) begin
          nxt_state.wrEn   = 1'b1;
          nxt_state.wrSel  = state_ff.dest;
          nxt_state.wrData = sext(product[`MSU_WORD_W-1:0]);
          // Accumulators are left untouched here.
        end else begin
          nxt_state.top    = sext(diff[`MSU_PROD_W-1:`MSU_WORD_W]);
          nxt_state.bottom = sext(diff[`MSU_WORD_W-1:0]);
        end
        nxt_state.stA   = 1'b0;
        nxt_state.stD   = 1'b0;
        nxt_state.state = msu_pkg::MSU_ST_IDLE;
      end
      default: nxt_state.state = msu_pkg::MSU_ST_IDLE;
    endcase
    // Busy and the exception flag are registered so that every output comes from a flop.
    nxt_state.bsy = (nxt_state.state != msu_pkg::MSU_ST_IDLE);
    nxt_state.exc = 1'b0;
  end

  // State register.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff        <= '0;
      state_ff.state  <= msu_pkg::MSU_ST_IDLE;
      state_ff.op     <= msu_pkg::MSU_OP_NONE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs come straight from the state register.
  assign busy        = state_ff.bsy;
  assign stallAccum  = state_ff.stA;
  assign stallDest   = state_ff.stD;
  assign pendDest    = state_ff.dest;
  assign accumTop    = state_ff.top;
  assign accumBottom = state_ff.bottom;
  assign gprWrEn     = state_ff.wrEn;
  assign gprWrSel    = state_ff.wrSel;
  assign gprWrData   = state_ff.wrData;
  assign arithExc    = state_ff.exc;

  // Subtract forms never write a general register.
  property p_noGprOnSub;
    @(posedge sys_clk) disable iff (!nrst)
      (state_ff.state == msu_pkg::MSU_ST_DONE && state_ff.op != msu_pkg::MSU_OP_MULR)
        |=> !gprWrEn;
  endproperty
  a_noGprOnSub: assert property (p_noGprOnSub) else $error("gpr written by subtract");

  // Register multiply writes the sign-extended low product word.
  property p_mulData;
    @(posedge sys_clk) disable iff (!nrst)
      (state_ff.state == msu_pkg::MSU_ST_DONE && state_ff.op == msu_pkg::MSU_OP_MULR)
        |=> gprWrEn && gprWrData == sext($past(product[`MSU_WORD_W-1:0]));
  endproperty
  a_mulData: assert property (p_mulData) else $error("bad multiply result");

  // Subtract result equals accumulator minus product.
  property p_subRes;
    @(posedge sys_clk) disable iff (!nrst)
      (state_ff.state == msu_pkg::MSU_ST_DONE && state_ff.op != msu_pkg::MSU_OP_MULR)
        |=> {accumTop[31:0], accumBottom[31:0]} == $past(accum) - $past(product);
  endproperty
  a_subRes: assert property (p_subRes) else $error("bad subtract result");

  // Accumulator halves are sign-extended.
  property p_sext;
    @(posedge sys_clk) disable iff (!nrst)
      accumTop[63:32] == {32{accumTop[31]}} && accumBottom[63:32] == {32{accumBottom[31]}};
  endproperty
  a_sext: assert property (p_sext) else $error("accumulator not sign-extended");

  // Signed product matches a signed reference.
  property p_signed;
    @(posedge sys_clk) disable iff (!nrst)
      (busy && state_ff.op == msu_pkg::MSU_OP_SUBS) |->
        product == 64'($signed(state_ff.opA)) * 64'($signed(state_ff.opB));
  endproperty
  a_signed: assert property (p_signed) else $error("signed product wrong");

  // Unsigned product matches an unsigned reference.
  property p_unsigned;
    @(posedge sys_clk) disable iff (!nrst)
      (busy && state_ff.op == msu_pkg::MSU_OP_SUBU) |->
        product == 64'(state_ff.opA) * 64'(state_ff.opB);
  endproperty
  a_unsigned: assert property (p_unsigned) else $error("unsigned product wrong");

  // No exception flag ever.
  property p_noExc;
    @(posedge sys_clk) disable iff (!nrst) !arithExc;
  endproperty
  a_noExc: assert property (p_noExc) else $error("exception raised");

  // An issue raises a stall the next cycle, cleared within a bounded time.
  property p_stall;
    @(posedge sys_clk) disable iff (!nrst)
      (!busy && issueValid && issueOp != 2'h3) |=> (stallAccum || stallDest)
        ##[2:4] !busy;
  endproperty
  a_stall: assert property (p_stall) else $error("stall window wrong");

  // The register write strobe stands for exactly one cycle.
  property p_wrPulse;
    @(posedge sys_clk) disable iff (!nrst)
      gprWrEn |=> !gprWrEn;
  endproperty
  a_wrPulse: assert property (p_wrPulse) else $error("write strobe too long");

  // Only one kind of result is pending at a time.
  property p_stallOne;
    @(posedge sys_clk) disable iff (!nrst)
      !(stallAccum && stallDest);
  endproperty
  a_stallOne: assert property (p_stallOne) else $error("both stall flags high");

  // Short src_b finishes in the short latency.
  property p_shortLat;
    @(posedge sys_clk) disable iff (!nrst)
      ($rose(busy) && shortB) |-> ##1 state_ff.state == msu_pkg::MSU_ST_DONE;
  endproperty
  a_shortLat: assert property (p_shortLat) else $error("short latency wrong");
endmodule : msu_unit

// >>> dv/msu_pipe_model.sv
// Issuing pipeline model that presents operands to the multiply-subtract unit.
`timescale 1ns/1ns
`include "msu_regs.svh"
module msu_pipe_model (
  input  wire logic                   sys_clk,
  output logic                        issueValid,
  output logic [1:0]                  issueOp,
  output logic [`MSU_GPR_W-1:0]       srcA,
  output logic [`MSU_GPR_W-1:0]       srcB,
  output logic [`MSU_DEST_W-1:0]      destSel
);
  // Idle values at time zero.
  initial begin
    issueValid = 1'b0;
    issueOp = 2'h3;
    srcA = 64'h0000_0000_0000_0000;
    srcB = 64'h0000_0000_0000_0000;
    destSel = 5'h0;
  end

  // One issue; the request stands until the taking edge, plus hold refused edges.
  task automatic issue(input logic [1:0] op, input logic [31:0] a, input logic [31:0] b,
                       input logic [4:0] dest, input int hold, output time tTake);
    @(posedge sys_clk);
    issueValid <= 1'b1;
    issueOp <= op;
    srcA <= {{32{a[31]}}, a};
    srcB <= {{32{b[31]}}, b};
    destSel <= dest;
    @(posedge sys_clk);
    tTake = $time;
    repeat (hold) @(posedge sys_clk);
    issueValid <= 1'b0;
    issueOp <= 2'h3;
    srcA <= ~srcA;
    srcB <= ~srcB;
  endtask : issue
endmodule : msu_pipe_model

// >>> dv/test_msu_unit.sv
// Self-checking bench for the multiply-subtract unit.
`timescale 1ns/1ns
`include "msu_regs.svh"
module test_msu_unit;
  typedef struct {logic [1:0] kind; logic [63:0] top, bot, data; logic [4:0] dest;
                  int lat; time tTake;} msu_note_t;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic issueValid, busy, stallAccum, stallDest, gprWrEn, arithExc, prevBusy = 1'b0;
  logic [1:0] issueOp;
  logic [63:0] srcA, srcB, accumTop, accumBottom, gprWrData, acc = 64'h0;
  logic [4:0] destSel, pendDest, gprWrSel;
  logic [31:0] seed = 32'h0000_D981;
  int miscompares = 0;
  int testsRun = 0;
  int cycles = 0;
  msu_note_t notes[$];

  msu_pipe_model msu_pipe_model_i (.sys_clk(sys_clk), .issueValid(issueValid),
    .issueOp(issueOp), .srcA(srcA), .srcB(srcB), .destSel(destSel));
  msu_unit msu_unit_i (.sys_clk(sys_clk), .nrst(nrst), .issueValid(issueValid),
    .issueOp(issueOp), .srcA(srcA), .srcB(srcB), .destSel(destSel), .busy(busy),
    .stallAccum(stallAccum), .stallDest(stallDest), .pendDest(pendDest),
    .accumTop(accumTop), .accumBottom(accumBottom), .gprWrEn(gprWrEn),
    .gprWrSel(gprWrSel), .gprWrData(gprWrData), .arithExc(arithExc));

  // Clock of 50 ns period.
  always #25 sys_clk = ~sys_clk;

  // Compares one value and counts it.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    testsRun++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // Xorshift source of random operands.
  function automatic logic [31:0] rnd_next();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd_next

  // Works out the expected result, issues the operation and waits for its write-back.
  task automatic run_op(input logic [1:0] op, input logic [31:0] a, input logic [31:0] b,
                        input int hold);
    msu_note_t n;
    logic [63:0] prod;
    time t;
    if (op == 2'h1) prod = {32'h0, a} * {32'h0, b};
    else prod = {{32{a[31]}}, a} * {{32{b[31]}}, b};
    n.kind = op;
    n.dest = a[4:0] ^ b[9:5];
    // Cycles from the taking edge to the write-back edge; a short src_b takes fewer.
    n.lat = ((op == 2'h1) ? (b[31:16] == 16'h0) : (b[31:15] == {17{b[31]}})) ?
            `MSU_LAT_SHORT : `MSU_LAT_LONG;
    if (op != 2'h2) acc = acc - prod;
    n.top = {{32{acc[63]}}, acc[63:32]};
    n.bot = {{32{acc[31]}}, acc[31:0]};
    n.data = {{32{prod[31]}}, prod[31:0]};
    n.tTake = 0;
    // The note is queued before the issue so the watcher has it at the first busy cycle.
    notes.push_back(n);
    msu_pipe_model_i.issue(op, a, b, n.dest, hold, t);
    notes[$].tTake = t;
    for (int k = 0; k < 20 && notes.size() != 0; k++) @(negedge sys_clk);
    // A result that never arrives counts as a mismatch.
    if (notes.size() != 0) begin
      check(64'(notes.size()), 64'h0);
      notes.delete();
    end
  endtask : run_op

  // Watches the outputs at the falling edge, where they have settled.
  always @(negedge sys_clk) begin
    msu_note_t n;
    if (!prevBusy && busy && notes.size() != 0) begin
      check(stallAccum, notes[0].kind != 2'h2);
      check(stallDest, notes[0].kind == 2'h2);
      if (notes[0].kind == 2'h2) check(pendDest, notes[0].dest);
    end
    if (gprWrEn && !(prevBusy && !busy)) check(1'b1, 1'b0);
    if (prevBusy && !busy) begin
      if (notes.size() == 0) check(1'b1, 1'b0);
      else begin
        n = notes.pop_front();
        check(64'(($time - 25 - n.tTake) / 50), 64'(n.lat));
        check(accumTop, n.top);
        check(accumBottom, n.bot);
        check(gprWrEn, n.kind == 2'h2);
        if (n.kind == 2'h2) check({gprWrSel, gprWrData}, {n.dest, n.data});
        check({stallAccum, stallDest, arithExc}, 3'h0);
      end
    end
    prevBusy <= busy;
  end

  // Cuts a hang short.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // Reset, directed boundary operands for every operation, then random operands.
  initial begin
    logic [31:0] r, b;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    check({accumTop, accumBottom}, 64'h0);
    check({busy, gprWrEn, arithExc}, 3'h0);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      run_op(2'(i), 32'h8000_0000, 32'h8000_0000, 0);
      run_op(2'(i), 32'h7FFF_FFFF, 32'hFFFF_8000, 0);
      run_op(2'(i), 32'h1234_5678, 32'h0000_8000, 1);
    end
    $display("test directed done");
    for (int i = 0; i < 60; i++) begin
      r = rnd_next();
      b = rnd_next();
      if (r[3]) b = {{16{b[15]}}, b[15:0]};
      run_op((r[2:1] == 2'h3) ? 2'h0 : r[2:1], rnd_next(), b, int'(r[4]));
    end
    $display("test random done");
    check(64'(notes.size()), 64'h0);
    report_and_stop();
  end
endmodule : test_msu_unit
